// *** iiss_io_model.sv ***
// behavioural model of the backplane modules and remote slaves feeding the block
`timescale 1ns/1ps
`default_nettype none

module iiss_io_model (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic load,
   input wire logic [2:0] load_addr,
   input wire logic [7:0] load_data,
   input wire logic push,
   input wire logic [2:0] push_addr,
   input wire logic [7:0] push_data,
   output logic [63:0] local_in,
   output logic rin_valid,
   input wire logic rin_ready,
   output logic [2:0] rin_addr,
   output logic [7:0] rin_data,
   input wire logic ref_fire,
   output logic dc_ref_pulse
);
   // the first capable slave marks its reference time with a one-cycle pulse
   always @(posedge ref_clk) begin
      if (srst)
         dc_ref_pulse <= 1'b0;
      else
         dc_ref_pulse <= ref_fire;
   end

   // local pins hold their level; the remote word is held until the handshake
   always @(posedge ref_clk) begin
      if (srst) begin
         local_in <= 64'h0;
         rin_valid <= 1'b0;
         rin_addr <= 3'h0;
         rin_data <= 8'h0;
      end else begin
         if (load)
            local_in[load_addr*8 +: 8] <= load_data;
         if (push) begin
            rin_valid <= 1'b1;
            rin_addr <= push_addr;
            rin_data <= push_data;
         end else if (rin_valid && rin_ready) begin
            // released lines show junk so a late read cannot pass by luck
            rin_valid <= 1'b0;
            rin_addr <= ~rin_addr;
            rin_data <= ~rin_data;
         end
      end
   end
endmodule : iiss_io_model

`default_nettype wire

// *** iiss_pkg.sv ***
// constants and types for the isochronous snapshot controller
package iiss_pkg;
   localparam int ADDR_W = 3;
   localparam int N_ADDR = 8;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int RIN_W = ADDR_W + DATA_W;
   localparam int PERIOD_W = 24;
   // clock and timing figures
   localparam int CLK_PERIOD_NS = 10;
   localparam int CYCLE_TIME_NS = 1000000;
   localparam int BLINK_HALF_MS = 250;
   localparam int NS_PER_MS = 1000000;
   localparam int CYCLE_TIME_CLKS = CYCLE_TIME_NS / CLK_PERIOD_NS;
   localparam int BLINK_HALF_CLKS = (BLINK_HALF_MS * NS_PER_MS) / CLK_PERIOD_NS;
   // diagnostic for a synchronous module that cannot run isochronously
   localparam logic [15:0] DIAG_NOT_ISO = 16'hEB05;
   localparam logic [PERIOD_W-1:0] PERIOD_ZERO = 24'h000000;
   localparam logic [PERIOD_W-1:0] PERIOD_ONE = 24'h000001;
   typedef enum logic [1:0] {
      IISS_F_IDLE,
      IISS_F_WAIT_PT,
      IISS_F_RUN
   } iiss_fast_state_t;
endpackage : iiss_pkg

// *** iiss_top.sv ***
// snapshot ownership, sync strobe, fast task sequencing and remote input fifo
`timescale 1ns/1ps
`default_nettype none

// small fifo for the remote input stream
module iiss_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;
   logic push;
   logic pop;

   // honest flags straight from the occupancy count
   assign in_ready = (count != DEPTH[PW:0]);
   assign out_valid = (count != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   // storage and pointers
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
      end
   end
endmodule : iiss_fifo

module iiss_top #(
   parameter int DEFAULT_PERIOD = iiss_pkg::CYCLE_TIME_CLKS,
   parameter int BLINK_HALF = iiss_pkg::BLINK_HALF_CLKS
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [iiss_pkg::PERIOD_W-1:0] cycle_period,
   input wire logic dc_ref_present,
   input wire logic dc_ref_pulse,
   output logic sync_strobe,
   input wire logic cfg_valid,
   input wire logic [iiss_pkg::ADDR_W-1:0] cfg_addr,
   input wire logic cfg_fast,
   input wire logic cfg_remote,
   input wire logic cfg_analog,
   input wire logic cfg_iso_capable,
   input wire logic [iiss_pkg::ADDR_W-1:0] main_end,
   output logic cfg_reject,
   output logic diag_valid,
   output logic [15:0] diag_code,
   output logic [iiss_pkg::N_ADDR-1:0] err_led,
   input wire logic [iiss_pkg::N_ADDR*iiss_pkg::DATA_W-1:0] local_in,
   output logic [iiss_pkg::N_ADDR*iiss_pkg::DATA_W-1:0] local_out,
   output logic [iiss_pkg::N_ADDR*iiss_pkg::DATA_W-1:0] remote_out,
   input wire logic rin_valid,
   output logic rin_ready,
   input wire logic [iiss_pkg::ADDR_W-1:0] rin_addr,
   input wire logic [iiss_pkg::DATA_W-1:0] rin_data,
   input wire logic main_req,
   input wire logic main_busy,
   input wire logic main_at_point,
   input wire logic main_done,
   output logic main_start,
   output logic preempt_req,
   output logic fast_start,
   input wire logic fast_done,
   input wire logic time_err_en,
   output logic time_err_start,
   output logic halted,
   input wire logic task_wr,
   input wire logic [iiss_pkg::ADDR_W-1:0] task_wr_addr,
   input wire logic [iiss_pkg::DATA_W-1:0] task_wr_data,
   input wire logic [iiss_pkg::ADDR_W-1:0] rd_addr,
   output logic [iiss_pkg::DATA_W-1:0] rd_data
);
   import iiss_pkg::*;

   localparam logic [PERIOD_W-1:0] DEF_PERIOD = DEFAULT_PERIOD[PERIOD_W-1:0];
   localparam logic [31:0] BLINK_LAST = 32'(BLINK_HALF - 1);

   iiss_fast_state_t fast_state;
   logic [N_ADDR*DATA_W-1:0] lin_meta;
   logic [N_ADDR*DATA_W-1:0] lin_sync;
   logic [2:0] ref_sh;
   logic ref_align;
   logic [PERIOD_W-1:0] period_cnt;
   logic [PERIOD_W-1:0] period_eff;
   logic [N_ADDR-1:0] fast_own;
   logic [N_ADDR-1:0] main_used;
   logic [N_ADDR-1:0] is_remote;
   logic [N_ADDR-1:0] is_analog;
   logic [N_ADDR-1:0] bad_iso;
   logic [N_ADDR-1:0] main_own;
   logic [N_ADDR-1:0] rel_mask;
   logic fast_out_ready;
   logic [DATA_W-1:0] in_snap [N_ADDR];
   logic [DATA_W-1:0] out_shadow [N_ADDR];
   logic [DATA_W-1:0] out_live [N_ADDR];
   logic [DATA_W-1:0] rstage [N_ADDR];
   logic [DATA_W-1:0] live_in [N_ADDR];
   logic [31:0] blink_cnt;
   logic blink;
   logic fq_valid;
   logic fq_ready;
   logic [RIN_W-1:0] fq_data;
   logic main_go;
   logic point_ok;

   // pin inputs pass two flops; only the second stage is read
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         lin_meta <= '0;
         lin_sync <= '0;
         ref_sh <= 3'h0;
      end else begin
         lin_meta <= local_in;
         lin_sync <= lin_meta;
         ref_sh <= {ref_sh[1:0], dc_ref_pulse};
      end
   end

   // edge of the reference pulse, taken from stages two and three
   assign ref_align = dc_ref_present && ref_sh[1] && !ref_sh[2];
   // zero period falls back to the configured default
   assign period_eff = (cycle_period == PERIOD_ZERO) ? DEF_PERIOD : cycle_period;

   // one timer serves backplane and fieldbus; it runs with or without slaves
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         period_cnt <= '0;
         sync_strobe <= 1'b0;
      end else if (ref_align) begin
         period_cnt <= '0; // phase snaps to the reference slave
         sync_strobe <= 1'b1;
      end else if (period_cnt >= period_eff - PERIOD_ONE) begin
         period_cnt <= '0;
         sync_strobe <= 1'b1;
      end else begin
         period_cnt <= period_cnt + PERIOD_ONE;
         sync_strobe <= 1'b0;
      end
   end

   // ownership table; a claim on an owned address is refused
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         fast_own <= '0;
         main_used <= '0;
         is_remote <= '0;
         is_analog <= '0;
         bad_iso <= '0;
         cfg_reject <= 1'b0;
         diag_valid <= 1'b0;
         diag_code <= 16'h0000;
      end else begin
         cfg_reject <= 1'b0;
         diag_valid <= 1'b0;
         if (cfg_valid) begin
            if (fast_own[cfg_addr] || main_used[cfg_addr]) begin
               cfg_reject <= 1'b1;
            end else if (!cfg_fast && (cfg_addr > main_end)) begin
               cfg_reject <= 1'b1; // main range ends at main_end
            end else begin
               is_remote[cfg_addr] <= cfg_remote;
               is_analog[cfg_addr] <= cfg_analog;
               if (cfg_fast) begin
                  fast_own[cfg_addr] <= 1'b1; // any address, gaps included
                  if (!cfg_remote && !cfg_analog && !cfg_iso_capable) begin
                     bad_iso[cfg_addr] <= 1'b1;
                     diag_valid <= 1'b1;
                     diag_code <= DIAG_NOT_ISO;
                  end
               end else begin
                  main_used[cfg_addr] <= 1'b1;
               end
            end
         end
      end
   end

   // main owns 0..main_end except gaps taken by the fast snapshot
   always_comb begin
      for (int a = 0; a < N_ADDR; a++) begin
         main_own[a] = (ADDR_W'(a) <= main_end) && !fast_own[a];
         rel_mask[a] = fast_own[a] && !is_analog[a] && fast_out_ready;
         live_in[a] = is_remote[a] ? rstage[a] : lin_sync[a*DATA_W +: DATA_W];
      end
   end

   // error lamp blink for modules unable to run isochronously
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         blink_cnt <= '0;
         blink <= 1'b0;
      end else if (blink_cnt >= BLINK_LAST) begin
         blink_cnt <= '0;
         blink <= !blink;
      end else begin
         blink_cnt <= blink_cnt + 32'h00000001;
      end
   end
   assign err_led = bad_iso & {N_ADDR{blink}};

   // remote inputs queue here; draining stalls in strobe cycles so staging holds still
   iiss_fifo #(
      .WIDTH(RIN_W),
      .DEPTH(FIFO_DEPTH)
   ) u_rin_fifo (
      .ref_clk(ref_clk),
      .srst(srst),
      .in_valid(rin_valid),
      .in_ready(rin_ready),
      .in_data({rin_addr, rin_data}),
      .out_valid(fq_valid),
      .out_ready(fq_ready),
      .out_data(fq_data)
   );
   assign fq_ready = !sync_strobe;

   // remote staging: words delivered a cycle ahead of the strobe that latches them
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int a = 0; a < N_ADDR; a++) begin
            rstage[a] <= '0;
         end
      end else if (fq_valid && fq_ready) begin
         rstage[fq_data[RIN_W-1:DATA_W]] <= fq_data[DATA_W-1:0];
      end
   end

   // consistency point: main idle or parked at a module boundary
   assign point_ok = !main_busy || main_at_point;
   assign preempt_req = (fast_state == IISS_F_WAIT_PT);
   assign main_go = main_req && !main_busy && (fast_state == IISS_F_IDLE) && !halted && !sync_strobe;

   // fast task sequencing and overrun handling
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         fast_state <= IISS_F_IDLE;
         fast_start <= 1'b0;
         time_err_start <= 1'b0;
         halted <= 1'b0;
         main_start <= 1'b0;
      end else begin
         fast_start <= 1'b0;
         time_err_start <= 1'b0;
         main_start <= main_go; // main starts on request, never on the strobe
         unique case (fast_state)
            IISS_F_IDLE: begin
               if (sync_strobe && !halted) begin
                  fast_state <= IISS_F_WAIT_PT; // inputs refreshed this edge
               end
            end
            IISS_F_WAIT_PT: begin
               if (sync_strobe) begin
                  if (time_err_en) begin
                     time_err_start <= 1'b1;
                  end else begin
                     halted <= 1'b1;
                     fast_state <= IISS_F_IDLE;
                  end
               end else if (point_ok) begin
                  fast_start <= 1'b1;
                  fast_state <= IISS_F_RUN;
               end
            end
            IISS_F_RUN: begin
               if (sync_strobe) begin
                  if (time_err_en) begin
                     time_err_start <= 1'b1;
                  end else begin
                     halted <= 1'b1;
                     fast_state <= IISS_F_IDLE;
                  end
               end else if (fast_done) begin
                  fast_state <= IISS_F_IDLE;
               end
            end
         endcase
      end
   end

   // outputs of the fast task count as prepared once it completes in time
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         fast_out_ready <= 1'b0;
      end else if (fast_state == IISS_F_RUN && fast_done && !sync_strobe) begin
         fast_out_ready <= 1'b1;
      end else if (sync_strobe) begin
         fast_out_ready <= 1'b0;
      end
   end

   // input snapshot: fast part at the strobe, fast analog at fast start, main part at main start
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int a = 0; a < N_ADDR; a++) begin
            in_snap[a] <= '0;
         end
      end else begin
         for (int a = 0; a < N_ADDR; a++) begin
            if (fast_own[a] && !is_analog[a] && sync_strobe && fast_state == IISS_F_IDLE && !halted) begin
               in_snap[a] <= live_in[a];
            end else if (fast_own[a] && is_analog[a] && fast_state == IISS_F_WAIT_PT && point_ok && !sync_strobe) begin
               in_snap[a] <= live_in[a]; // analog read just before start
            end else if (main_own[a] && main_go) begin
               in_snap[a] <= live_in[a];
            end
         end
      end
   end

   // output shadow written by whichever task is running
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int a = 0; a < N_ADDR; a++) begin
            out_shadow[a] <= '0;
         end
      end else if (task_wr) begin
         out_shadow[task_wr_addr] <= task_wr_data;
      end
   end

   // live outputs: fast at the strobe, analog at fast done, main at main done
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int a = 0; a < N_ADDR; a++) begin
            out_live[a] <= '0;
         end
      end else begin
         for (int a = 0; a < N_ADDR; a++) begin
            if (sync_strobe && rel_mask[a]) begin
               out_live[a] <= out_shadow[a];
            end else if (fast_own[a] && is_analog[a] && fast_state == IISS_F_RUN && fast_done) begin
               out_live[a] <= out_shadow[a];
            end else if (main_own[a] && main_done) begin
               out_live[a] <= out_shadow[a];
            end
         end
      end
   end

   // local and remote images come from the same flops on the same edge
   always_comb begin
      for (int a = 0; a < N_ADDR; a++) begin
         local_out[a*DATA_W +: DATA_W] = is_remote[a] ? '0 : out_live[a];
         remote_out[a*DATA_W +: DATA_W] = is_remote[a] ? out_live[a] : '0;
      end
   end

   // read port open to every task
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rd_data <= '0;
      end else begin
         rd_data <= in_snap[rd_addr];
      end
   end

   // helper: cycles since the last strobe; the first strobe comes a full period after release
   logic [PERIOD_W-1:0] gap_cnt;
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         gap_cnt <= PERIOD_ZERO;
      end else if (sync_strobe) begin
         gap_cnt <= PERIOD_ONE;
      end else begin
         gap_cnt <= gap_cnt + PERIOD_ONE;
      end
   end

   overrun_halt_a: assert property (@(posedge ref_clk) disable iff (srst)
      sync_strobe && fast_state != IISS_F_IDLE && !time_err_en |=> halted && fast_state == IISS_F_IDLE)
      else $error("overrun did not halt");
   overrun_call_a: assert property (@(posedge ref_clk) disable iff (srst)
      sync_strobe && fast_state != IISS_F_IDLE && time_err_en |=> time_err_start)
      else $error("overrun did not call time error task");
   start_point_a: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(fast_start) |-> $past(point_ok) && $past(fast_state) == IISS_F_WAIT_PT)
      else $error("fast task started outside a consistency point");
   release_edge_a: assert property (@(posedge ref_clk) disable iff (srst)
      sync_strobe && rel_mask[1] && !is_remote[1] |=> local_out[2*DATA_W-1:DATA_W] == $past(out_shadow[1]))
      else $error("prepared output not released at strobe");
   dup_reject_a: assert property (@(posedge ref_clk) disable iff (srst)
      cfg_valid && (fast_own[cfg_addr] || main_used[cfg_addr]) |=> cfg_reject && $stable(fast_own))
      else $error("duplicate claim accepted");
   main_range_a: assert property (@(posedge ref_clk) disable iff (srst)
      cfg_valid && !cfg_fast && cfg_addr > main_end |=> cfg_reject)
      else $error("main claim beyond end accepted");
   diag_code_a: assert property (@(posedge ref_clk) disable iff (srst)
      cfg_valid && cfg_fast && !cfg_remote && !cfg_analog && !cfg_iso_capable
      && !fast_own[cfg_addr] && !main_used[cfg_addr] |=> diag_valid && diag_code == DIAG_NOT_ISO)
      else $error("missing isochronous diagnostic");
   strobe_gap_a: assert property (@(posedge ref_clk) disable iff (srst)
      sync_strobe |-> gap_cnt <= period_eff)
      else $error("strobe gap longer than one cycle period");
   halt_sticky_a: assert property (@(posedge ref_clk) disable iff (srst)
      halted |=> halted && !fast_start)
      else $error("halted state left or task started");
   snap_frozen_a: assert property (@(posedge ref_clk) disable iff (srst)
      fast_state == IISS_F_RUN && fast_own[1] && !is_analog[1] |=> $stable(in_snap[1]))
      else $error("fast snapshot changed during run");

   full_cycle_c: cover property (@(posedge ref_clk) disable iff (srst)
      fast_start ##[1:1000] (fast_state == IISS_F_RUN && fast_done));
   overrun_c: cover property (@(posedge ref_clk) disable iff (srst) $rose(halted));
   reject_c: cover property (@(posedge ref_clk) disable iff (srst) cfg_reject);
   align_c: cover property (@(posedge ref_clk) disable iff (srst) ref_align);
endmodule : iiss_top
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the isochronous snapshot controller
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import iiss_pkg::*;
   logic ref_clk, srst, cfg_valid, cfg_fast, cfg_remote, cfg_analog, cfg_iso, sync_strobe;
   logic cfg_reject, diag_valid, rin_valid, rin_ready, main_req, main_busy, main_at_point;
   logic main_done, main_start, preempt_req, fast_start, fast_done, time_err_en, time_err_start;
   logic halted, task_wr, load, push, dc_ref_pulse, dc_ref_present, ref_fire;
   logic [2:0] cfg_addr, rin_addr, task_wr_addr, rd_addr, load_addr, push_addr;
   logic [7:0] rin_data, task_wr_data, rd_data, load_data, push_data, err_led;
   logic [15:0] diag_code;
   logic [63:0] local_in, local_out, remote_out;
   int mismatches = 0;
   int compares = 0;

   iiss_top #(.DEFAULT_PERIOD(40), .BLINK_HALF(8)) dut (.ref_clk(ref_clk), .srst(srst),
      .cycle_period(24'h000028), .dc_ref_present(dc_ref_present), .dc_ref_pulse(dc_ref_pulse),
      .sync_strobe(sync_strobe), .cfg_valid(cfg_valid), .cfg_addr(cfg_addr), .cfg_fast(cfg_fast),
      .cfg_remote(cfg_remote), .cfg_analog(cfg_analog), .cfg_iso_capable(cfg_iso),
      .main_end(3'h3), .cfg_reject(cfg_reject), .diag_valid(diag_valid), .diag_code(diag_code),
      .err_led(err_led), .local_in(local_in), .local_out(local_out), .remote_out(remote_out),
      .rin_valid(rin_valid), .rin_ready(rin_ready), .rin_addr(rin_addr), .rin_data(rin_data),
      .main_req(main_req), .main_busy(main_busy), .main_at_point(main_at_point),
      .main_done(main_done), .main_start(main_start), .preempt_req(preempt_req),
      .fast_start(fast_start), .fast_done(fast_done), .time_err_en(time_err_en),
      .time_err_start(time_err_start), .halted(halted), .task_wr(task_wr),
      .task_wr_addr(task_wr_addr), .task_wr_data(task_wr_data), .rd_addr(rd_addr),
      .rd_data(rd_data));

   iiss_io_model partner (.ref_clk(ref_clk), .srst(srst), .load(load), .load_addr(load_addr),
      .load_data(load_data), .push(push), .push_addr(push_addr), .push_data(push_data),
      .local_in(local_in), .rin_valid(rin_valid), .rin_ready(rin_ready), .rin_addr(rin_addr),
      .rin_data(rin_data), .ref_fire(ref_fire), .dc_ref_pulse(dc_ref_pulse));

   // clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize

   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk_val

   // bounded wait for one cycle of a pulse; returns the cycles spent
   task automatic wait_high(ref logic sig, input int limit, output int n);
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (sig !== 1'b1 && n < limit);
      chk_bit(sig, 1'b1);
   endtask : wait_high

   task automatic cfg(input logic [2:0] a, input logic f, r, an, iso, output logic rej, dg);
      @(posedge ref_clk);
      cfg_valid <= 1'b1;
      cfg_addr <= a;
      cfg_fast <= f;
      cfg_remote <= r;
      cfg_analog <= an;
      cfg_iso <= iso;
      @(posedge ref_clk);
      cfg_valid <= 1'b0;
      // the answer stands only in the cycle after the request edge
      #1;
      rej = cfg_reject;
      dg = diag_valid;
   endtask : cfg

   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      rd_addr <= a;
      repeat (2) @(posedge ref_clk);
      #1;
      v = rd_data;
   endtask : rd

   task automatic test_period();
      int n;
      wait_high(sync_strobe, 100, n);
      wait_high(sync_strobe, 100, n);
      chk_val(16'(n), 16'h0028);
   endtask : test_period

   task automatic test_config();
      logic rej, dg;
      int n;
      cfg(3'h1, 1, 0, 0, 1, rej, dg);
      chk_bit(rej, 1'b0);
      cfg(3'h1, 0, 0, 0, 1, rej, dg);
      chk_bit(rej, 1'b1);
      cfg(3'h5, 0, 0, 0, 1, rej, dg);
      chk_bit(rej, 1'b1);
      cfg(3'h2, 0, 0, 0, 1, rej, dg);
      chk_bit(rej, 1'b0);
      cfg(3'h6, 1, 1, 0, 1, rej, dg);
      chk_bit(rej, 1'b0);
      cfg(3'h7, 1, 0, 1, 0, rej, dg);
      chk_bit(dg, 1'b0);
      cfg(3'h4, 1, 0, 0, 0, rej, dg);
      chk_bit(dg, 1'b1);
      chk_val(diag_code, DIAG_NOT_ISO);
      // catch a rising lamp edge, then it stands one half period and goes dark
      n = 0;
      while (err_led[4] !== 1'b0 && n < 20) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      n = 0;
      while (err_led[4] !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk_bit(err_led[4], 1'b1);
      repeat (7) @(posedge ref_clk);
      #1;
      chk_bit(err_led[4], 1'b1);
      repeat (2) @(posedge ref_clk);
      #1;
      chk_bit(err_led[4], 1'b0);
   endtask : test_config

   task automatic test_fast_cycle();
      logic [7:0] v;
      int n;
      @(posedge ref_clk);
      load <= 1'b1;
      load_addr <= 3'h1;
      load_data <= 8'h5A;
      push <= 1'b1;
      push_addr <= 3'h6;
      push_data <= 8'hC3;
      main_busy <= 1'b1;
      main_at_point <= 1'b0;
      // retire the fast task left running by the earlier strobes
      fast_done <= 1'b1;
      @(posedge ref_clk);
      load <= 1'b0;
      push <= 1'b0;
      fast_done <= 1'b0;
      wait_high(sync_strobe, 100, n);
      @(posedge ref_clk);
      #1;
      chk_bit(preempt_req, 1'b1);
      // no start while the main task sits between consistency points
      repeat (4) begin
         @(posedge ref_clk);
         #1;
         chk_bit(fast_start, 1'b0);
      end
      @(posedge ref_clk);
      main_at_point <= 1'b1;
      wait_high(fast_start, 5, n);
      rd(3'h1, v);
      chk_val({8'h00, v}, 16'h005A);
      rd(3'h6, v);
      chk_val({8'h00, v}, 16'h00C3);
      @(posedge ref_clk);
      task_wr <= 1'b1;
      task_wr_addr <= 3'h1;
      task_wr_data <= 8'h3C;
      @(posedge ref_clk);
      task_wr_addr <= 3'h6;
      task_wr_data <= 8'h96;
      @(posedge ref_clk);
      task_wr <= 1'b0;
      fast_done <= 1'b1;
      @(posedge ref_clk);
      fast_done <= 1'b0;
      main_busy <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk_val({8'h00, local_out[15:8]}, 16'h0000);
      wait_high(sync_strobe, 100, n);
      @(posedge ref_clk);
      #1;
      chk_val({local_out[15:8], remote_out[55:48]}, 16'h3C96);
   endtask : test_fast_cycle

   task automatic test_overrun();
      int n;
      // the time-error task is configured from reset on
      wait_high(fast_start, 100, n);
      wait_high(sync_strobe, 100, n);
      @(posedge ref_clk);
      #1;
      chk_bit(time_err_start, 1'b1);
      chk_bit(halted, 1'b0);
      @(posedge ref_clk);
      fast_done <= 1'b1;
      time_err_en <= 1'b0;
      @(posedge ref_clk);
      fast_done <= 1'b0;
      main_req <= 1'b1;
      wait_high(main_start, 5, n);
      wait_high(fast_start, 100, n);
      wait_high(sync_strobe, 100, n);
      @(posedge ref_clk);
      #1;
      chk_bit(halted, 1'b1);
      n = 0;
      repeat (90) begin
         @(posedge ref_clk);
         #1;
         if (fast_start === 1'b1 || main_start === 1'b1)
            n++;
      end
      chk_val(16'(n), 16'h0000);
   endtask : test_overrun

   task automatic test_align();
      int n;
      @(posedge ref_clk);
      dc_ref_present <= 1'b1;
      ref_fire <= 1'b1;
      @(posedge ref_clk);
      ref_fire <= 1'b0;
      // model flop, two sync stages and the strobe flop put the strobe three edges on
      wait_high(sync_strobe, 100, n);
      chk_val(16'(n), 16'h0003);
      wait_high(sync_strobe, 100, n);
      chk_val(16'(n), 16'h0028);
   endtask : test_align

   // watchdog sized well past the few strobe periods the tests need
   initial begin
      repeat (5000) @(posedge ref_clk);
      mismatches++;
      summarize();
   end

   // main sequence
   initial begin
      {srst, cfg_valid, cfg_fast, cfg_remote, cfg_analog, cfg_iso, main_req, main_busy} = 8'h80;
      // time-error task configured, so idle strobes before the fast test cannot halt
      {main_at_point, main_done, fast_done, time_err_en, task_wr, load, push} = 7'h08;
      {dc_ref_present, ref_fire} = 2'h0;
      {cfg_addr, task_wr_addr, rd_addr, load_addr, push_addr} = 15'h0000;
      {task_wr_data, load_data, push_data} = 24'h000000;
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
      test_period();
      test_config();
      test_fast_cycle();
      test_overrun();
      test_align();
      summarize();
   end
endmodule : testbench

`default_nettype wire
